/* File: common/c2dma_pkg.sv */
// shared constants, types and register map of the channel-two dma control block
package c2dma_pkg;
    localparam int ADDR_W = 12; // byte address width on the register bus
    localparam int UNIT_BYTES = 32; // one processor transfer unit
    localparam int END_BIT = 19; // end flag position in the status and mask words
    localparam logic [31:0] LEN_MAX = 32'h0100_0000; // 16 megabytes
    localparam logic [31:0] UNIT_COUNT_MAX = 32'h0008_0000; // units in 16 megabytes
    // own register block offsets
    localparam logic [ADDR_W-1:0] OFF_DEST = 12'h800; // chan_dest_addr
    localparam logic [ADDR_W-1:0] OFF_LEN = 12'h804; // chan_byte_length
    localparam logic [ADDR_W-1:0] OFF_START = 12'h808; // chan_start_ctl
    localparam logic [ADDR_W-1:0] OFF_NSTAT = 12'h900; // normal_irq_status
    localparam logic [ADDR_W-1:0] OFF_XSTAT = 12'h904; // external_irq_status
    localparam logic [ADDR_W-1:0] OFF_ESTAT = 12'h908; // error_irq_status
    localparam logic [ADDR_W-1:0] OFF_MASK2 = 12'h930; // level2_normal_mask
    localparam logic [ADDR_W-1:0] OFF_MASK4 = 12'h940; // level4_normal_mask
    localparam logic [ADDR_W-1:0] OFF_MASK6 = 12'h950; // level6_normal_mask
    localparam logic [ADDR_W-1:0] OFF_AUX = 12'h960; // channel_irq_enable drive
    // processor-side registers, map only: kept by the processor dma controller
    localparam logic [31:0] OFF_UNIT_COUNT_TWO = 32'hffa0_0028;
    localparam logic [31:0] OFF_CHAN_CTL_TWO = 32'hffa0_002c;
    localparam logic [31:0] OFF_OP_CTL = 32'hffa0_0040;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // destination windows, decided on address bits [28:23]
    localparam logic [5:0] WIN_CONV = 6'h20; // 0x1000_0000 .. 0x107f_ffe0
    localparam logic [5:0] WIN_YUV = 6'h21; // 0x1080_0000 .. 0x10ff_ffe0
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {RT_CONV, RT_YUV, RT_DIRECT} c2dma_route_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} c2dma_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } c2dma_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } c2dma_axi_rsp_t;
endpackage

/* File: rtl/c2dma_axil_slave.sv */
// axi4-lite slave front end: turns bus traffic into one-cycle register strobes
`timescale 1ns/100ps
module c2dma_axil_slave (
    input wire logic mclk,
    input wire logic rst,
    input wire c2dma_pkg::c2dma_axi_req_t axiReq,
    output c2dma_pkg::c2dma_axi_rsp_t axiRsp,
    output logic wrEn,
    output logic [c2dma_pkg::ADDR_W-1:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    output logic [c2dma_pkg::ADDR_W-1:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);
    typedef struct packed {
        logic awSeen; // address half of a write held
        logic wSeen; // data half of a write held
        logic [c2dma_pkg::ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rPend; // read address taken, data next cycle
        logic [c2dma_pkg::ADDR_W-1:0] raddr;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } c2dma_slv_t;

    c2dma_slv_t s_q, s_d;
    logic awAcc, wAcc, arAcc;

    // ready terms: one write and one read outstanding at most
    assign awAcc = axiReq.awvalid && !s_q.awSeen && !s_q.bvalid;
    assign wAcc = axiReq.wvalid && !s_q.wSeen && !s_q.bvalid;
    assign arAcc = axiReq.arvalid && !s_q.rPend && !s_q.rvalid;
    // write commits once both halves are held and no response is pending
    assign wrEn = s_q.awSeen && s_q.wSeen && !s_q.bvalid;
    assign wrAddr = s_q.waddr;
    assign wrData = s_q.wdata;
    assign wrStrb = s_q.wstrb;
    assign rdAddr = s_q.raddr;

    // bus outputs; readies combinational, payloads from flops
    always_comb begin
        axiRsp.awready = !s_q.awSeen && !s_q.bvalid;
        axiRsp.wready = !s_q.wSeen && !s_q.bvalid;
        axiRsp.bresp = s_q.bresp;
        axiRsp.bvalid = s_q.bvalid;
        axiRsp.arready = !s_q.rPend && !s_q.rvalid;
        axiRsp.rdata = s_q.rdata;
        axiRsp.rresp = s_q.rresp;
        axiRsp.rvalid = s_q.rvalid;
    end

    // next state of both channels
    always_comb begin
        s_d = s_q;
        if (awAcc) begin
            s_d.awSeen = 1'b1;
            s_d.waddr = axiReq.awaddr;
        end
        if (wAcc) begin
            s_d.wSeen = 1'b1;
            s_d.wdata = axiReq.wdata;
            s_d.wstrb = axiReq.wstrb;
        end
        if (wrEn) begin
            s_d.awSeen = 1'b0;
            s_d.wSeen = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wrOk ? c2dma_pkg::RESP_OKAY : c2dma_pkg::RESP_SLVERR;
        end else if (s_q.bvalid && axiReq.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (arAcc) begin
            s_d.rPend = 1'b1;
            s_d.raddr = axiReq.araddr;
        end
        // data is captured a cycle after the address so the mux sees a stable index
        if (s_q.rPend) begin
            s_d.rPend = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rdata = rdData;
            s_d.rresp = rdOk ? c2dma_pkg::RESP_OKAY : c2dma_pkg::RESP_SLVERR;
        end else if (s_q.rvalid && axiReq.rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

/* File: rtl/c2dma_ctrl.sv */
// channel-two dma control: destination, length, start/stop and end interrupt
`timescale 1ns/100ps
module c2dma_ctrl #(
    parameter int UNIT_W = 256 // payload bits of one 32-byte unit
) (
    input wire logic mclk,
    input wire logic rst,
    input wire c2dma_pkg::c2dma_axi_req_t axiReq,
    output c2dma_pkg::c2dma_axi_rsp_t axiRsp,
    output logic srcReq,
    input wire logic srcUnitValid,
    output logic srcUnitReady,
    input wire logic [UNIT_W-1:0] srcData,
    output logic dstValid,
    output logic [31:0] dstAddr,
    output c2dma_pkg::c2dma_route_t dstRoute,
    output logic [UNIT_W-1:0] dstData,
    output logic chanIrqEnDrv,
    output logic irqLevel2,
    output logic irqLevel4,
    output logic irqLevel6
);
    if (UNIT_W != 8 * c2dma_pkg::UNIT_BYTES) begin : g_bad
        $error("UNIT_W must carry exactly one 32-byte unit");
    end

    typedef struct packed {
        c2dma_pkg::c2dma_state_t state;
        logic [31:0] dest; // chan_dest_addr
        logic [31:0] len; // chan_byte_length
        logic endFlag; // chan_end_irq_flag
        logic mask2;
        logic mask4;
        logic mask6;
        logic irqEnDrv; // drive for channel_irq_enable
        logic dValid;
        logic [31:0] dAddr;
        c2dma_pkg::c2dma_route_t dRoute;
        logic [UNIT_W-1:0] dData;
    } c2dma_ctl_t;

    c2dma_ctl_t s_q, s_d;
    logic wrEn, wrOk, rdOk, accept, busy;
    logic [c2dma_pkg::ADDR_W-1:0] wrAddr, rdAddr;
    logic [31:0] wrData, rdData;
    logic [3:0] wrStrb;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // legal length: whole units, one unit up to 16 megabytes
    function automatic logic lenOk(input logic [31:0] len);
        return (len[4:0] == 5'h00) && (len != c2dma_pkg::RST_ZERO)
            && (len <= c2dma_pkg::LEN_MAX);
    endfunction

    // routing from destination address
    function automatic c2dma_pkg::c2dma_route_t routeOf(input logic [31:0] a);
        if (a[28:23] == c2dma_pkg::WIN_CONV) begin
            return c2dma_pkg::RT_CONV;
        end else if (a[28:23] == c2dma_pkg::WIN_YUV) begin
            return c2dma_pkg::RT_YUV;
        end
        return c2dma_pkg::RT_DIRECT;
    endfunction

    // address decode shared by read and write
    function automatic logic mapped(input logic [c2dma_pkg::ADDR_W-1:0] a);
        case (a)
            c2dma_pkg::OFF_DEST, c2dma_pkg::OFF_LEN, c2dma_pkg::OFF_START,
            c2dma_pkg::OFF_NSTAT, c2dma_pkg::OFF_XSTAT, c2dma_pkg::OFF_ESTAT,
            c2dma_pkg::OFF_MASK2, c2dma_pkg::OFF_MASK4, c2dma_pkg::OFF_MASK6,
            c2dma_pkg::OFF_AUX: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    c2dma_axil_slave u_slave (
        .mclk(mclk),
        .rst(rst),
        .axiReq(axiReq),
        .axiRsp(axiRsp),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    assign wrOk = mapped(wrAddr);
    assign rdOk = mapped(rdAddr);
    // start stays one while running or draining a stop
    assign busy = (s_q.state != c2dma_pkg::ST_IDLE);
    // units are taken only while running; a stop closes the gate from the cycle after it is written
    assign srcUnitReady = (s_q.state == c2dma_pkg::ST_RUN);
    assign srcReq = srcUnitReady;
    assign accept = srcUnitValid && srcUnitReady;

    // read mux; unused status words and bits read zero
    always_comb begin
        rdData = c2dma_pkg::RST_ZERO;
        case (rdAddr)
            c2dma_pkg::OFF_DEST: rdData = s_q.dest;
            c2dma_pkg::OFF_LEN: rdData = s_q.len;
            c2dma_pkg::OFF_START: rdData[0] = busy;
            c2dma_pkg::OFF_NSTAT: rdData[c2dma_pkg::END_BIT] = s_q.endFlag;
            c2dma_pkg::OFF_MASK2: rdData[c2dma_pkg::END_BIT] = s_q.mask2;
            c2dma_pkg::OFF_MASK4: rdData[c2dma_pkg::END_BIT] = s_q.mask4;
            c2dma_pkg::OFF_MASK6: rdData[c2dma_pkg::END_BIT] = s_q.mask6;
            c2dma_pkg::OFF_AUX: rdData[0] = s_q.irqEnDrv;
            default: rdData = c2dma_pkg::RST_ZERO;
        endcase
    end

    // register writes, transfer sequencing and end flag
    always_comb begin
        s_d = s_q;
        s_d.dValid = 1'b0;
        if (wrEn) begin
            case (wrAddr)
                // setup registers are frozen while busy, so a stray write cannot
                // corrupt the resume point
                c2dma_pkg::OFF_DEST: begin
                    if (!busy) begin
                        s_d.dest = merge(s_q.dest, wrData, wrStrb);
                    end
                end
                c2dma_pkg::OFF_LEN: begin
                    if (!busy) begin
                        s_d.len = merge(s_q.len, wrData, wrStrb);
                    end
                end
                c2dma_pkg::OFF_START: begin
                    if (wrStrb[0] && wrData[0]) begin
                        // start and resume are the same: work picks up at dest/len
                        if (!busy && lenOk(s_q.len)) begin
                            s_d.state = c2dma_pkg::ST_RUN;
                        end
                    end else if (wrStrb[0] && s_q.state == c2dma_pkg::ST_RUN) begin
                        s_d.state = c2dma_pkg::ST_STOP;
                    end
                end
                c2dma_pkg::OFF_NSTAT: begin
                    if (wrStrb[2] && wrData[c2dma_pkg::END_BIT]) begin
                        s_d.endFlag = 1'b0;
                    end
                end
                c2dma_pkg::OFF_MASK2: begin
                    if (wrStrb[2]) begin
                        s_d.mask2 = wrData[c2dma_pkg::END_BIT];
                    end
                end
                c2dma_pkg::OFF_MASK4: begin
                    if (wrStrb[2]) begin
                        s_d.mask4 = wrData[c2dma_pkg::END_BIT];
                    end
                end
                c2dma_pkg::OFF_MASK6: begin
                    if (wrStrb[2]) begin
                        s_d.mask6 = wrData[c2dma_pkg::END_BIT];
                    end
                end
                c2dma_pkg::OFF_AUX: begin
                    if (wrStrb[0]) begin
                        s_d.irqEnDrv = wrData[0];
                    end
                end
                default: begin
                end
            endcase
        end
        case (s_q.state)
            c2dma_pkg::ST_RUN: begin
                if (accept) begin
                    s_d.dValid = 1'b1;
                    s_d.dAddr = s_q.dest;
                    s_d.dRoute = routeOf(s_q.dest);
                    s_d.dData = srcData;
                    s_d.len = s_q.len - 32'(c2dma_pkg::UNIT_BYTES);
                    if (routeOf(s_q.dest) != c2dma_pkg::RT_YUV) begin
                        s_d.dest = s_q.dest + 32'(c2dma_pkg::UNIT_BYTES);
                    end // yuv keeps its programmed destination
                    // last unit ends normally even if a stop lands this cycle;
                    // the flag set beats a clear written in the same cycle
                    if (s_q.len == 32'(c2dma_pkg::UNIT_BYTES)) begin
                        s_d.state = c2dma_pkg::ST_IDLE;
                        s_d.endFlag = 1'b1;
                    end
                end
            end
            c2dma_pkg::ST_STOP: begin
                // gate shut on entering this state, nothing in flight: halt, no flag
                s_d.state = c2dma_pkg::ST_IDLE;
            end
            default: begin
            end
        endcase
    end

    // register stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs from flops; interrupt lines gated by level masks
    assign dstValid = s_q.dValid;
    assign dstAddr = s_q.dAddr;
    assign dstRoute = s_q.dRoute;
    assign dstData = s_q.dData;
    assign chanIrqEnDrv = s_q.irqEnDrv;
    assign irqLevel2 = s_q.endFlag && s_q.mask2;
    assign irqLevel4 = s_q.endFlag && s_q.mask4;
    assign irqLevel6 = s_q.endFlag && s_q.mask6;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic wrStart1, wrStop, wrClr;
    assign wrStart1 = wrEn && wrAddr == c2dma_pkg::OFF_START && wrStrb[0] && wrData[0];
    assign wrStop = wrEn && wrAddr == c2dma_pkg::OFF_START && wrStrb[0] && !wrData[0];
    assign wrClr = wrEn && wrAddr == c2dma_pkg::OFF_NSTAT && wrStrb[2]
        && wrData[c2dma_pkg::END_BIT];

    property p_end;
        accept && s_q.len == 32'h20 |=> !busy && s_q.endFlag && s_q.len == 32'h0;
    endproperty
    a_end: assert property (p_end) else $error("normal end missed");
    property p_irq;
        (irqLevel2 || irqLevel4 || irqLevel6) |-> s_q.endFlag;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without end flag");
    property p_clr;
        wrClr && !(accept && s_q.len == 32'h20) |=> !s_q.endFlag && !irqLevel2;
    endproperty
    a_clr: assert property (p_clr) else $error("end flag not cleared");
    property p_stop;
        wrStop && s_q.state == c2dma_pkg::ST_RUN && !accept |=> busy ##1 !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("stop timing wrong");
    property p_noflag;
        s_q.state == c2dma_pkg::ST_STOP && !s_q.endFlag |=> !s_q.endFlag;
    endproperty
    a_noflag: assert property (p_noflag) else $error("stop set end flag");
    property p_len;
        accept |=> s_q.len == $past(s_q.len) - 32'h20 && dstValid;
    endproperty
    a_len: assert property (p_len) else $error("length not reduced");
    property p_yuv;
        accept && routeOf(s_q.dest) == c2dma_pkg::RT_YUV |=> s_q.dest == $past(s_q.dest);
    endproperty
    a_yuv: assert property (p_yuv) else $error("yuv destination moved");
    property p_dir;
        accept && routeOf(s_q.dest) != c2dma_pkg::RT_YUV
            |=> s_q.dest == $past(s_q.dest) + 32'h20;
    endproperty
    a_dir: assert property (p_dir) else $error("destination not advanced");
    property p_refuse;
        wrStart1 && !busy && !lenOk(s_q.len) |=> !busy [*2];
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad length started");
    property p_go;
        wrStart1 && !busy && lenOk(s_q.len) |=> srcUnitReady && srcReq;
    endproperty
    a_go: assert property (p_go) else $error("start or resume ignored");

    c_end: cover property (accept && s_q.len == 32'h20 ##1 irqLevel2);
    c_stop: cover property (wrStop && srcUnitReady ##2 !busy);
    c_resume: cover property (s_q.state == c2dma_pkg::ST_STOP ##[1:20] wrStart1 && !busy);
    c_yuv: cover property (dstValid && dstRoute == c2dma_pkg::RT_YUV);
endmodule

/* File: dv/c2dma_src_model.sv */
// source-side model: offers 32-byte units to the channel while it runs
`timescale 1ns/100ps
// the model stands for a source already set up with a listed control encoding
// and with the operation control bits checked, so it only streams units
// it never bursts into the texture window while the channel runs
module c2dma_src_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic srcReq,
    input wire logic srcUnitReady,
    input wire logic slow,
    output logic srcUnitValid,
    output logic [255:0] srcData
);
    logic [31:0] unitNo; // units handed over since reset
    logic [1:0] gap; // stall counter for slow mode
    // a unit stays offered until taken; between units the payload is scrambled
    always @(posedge mclk) begin
        if (rst) begin
            srcUnitValid <= 1'b0;
            unitNo <= '0;
            gap <= '0;
            srcData <= '1;
        end else if (srcUnitValid && srcUnitReady) begin
            // one handshake is one whole 32-byte unit
            unitNo <= unitNo + 32'h1;
            srcUnitValid <= !slow; // fast mode streams back to back
            srcData <= {8{unitNo + 32'h1}};
        end else if (!srcUnitValid) begin
            gap <= gap + 2'h1;
            // source address stays on unit boundaries, so a unit is never split
            if (srcReq && (!slow || gap == 2'h3)) begin
                srcUnitValid <= 1'b1;
                srcData <= {8{unitNo}};
            end else begin
                srcData <= ~srcData;
            end
        end
    end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the channel-two dma control block
`timescale 1ns/100ps
module testbench;
    typedef struct {logic [11:0] a; logic [31:0] d; logic wr; logic [31:0] e; logic [1:0] r;}
        c2dma_row_t;
    logic mclk = 1'b0;
    logic rst;
    logic slow; // source stalls between units
    c2dma_pkg::c2dma_axi_req_t req;
    c2dma_pkg::c2dma_axi_rsp_t rsp;
    logic srcReq, srcUnitValid, srcUnitReady, dstValid, chanIrqEnDrv;
    logic irqLevel2, irqLevel4, irqLevel6;
    logic [255:0] srcData, dstData;
    logic [31:0] dstAddr, expAddr, rd, base, n;
    logic [1:0] rr;
    c2dma_pkg::c2dma_route_t dstRoute, expRoute;
    logic expYuv;
    int failCount = 0, compares = 0, cycles = 0;
    logic [31:0] unitCnt; // delivered units since reset
    // register rows: reset values, masks, read-only and unmapped places
    c2dma_row_t rows[12] = '{
        '{c2dma_pkg::OFF_DEST, 0, 0, 0, 0}, '{c2dma_pkg::OFF_LEN, 0, 0, 0, 0},
        '{c2dma_pkg::OFF_START, 0, 0, 0, 0}, '{c2dma_pkg::OFF_NSTAT, 0, 0, 0, 0},
        '{c2dma_pkg::OFF_XSTAT, 0, 0, 0, 0}, '{c2dma_pkg::OFF_MASK6, 0, 0, 0, 0},
        '{c2dma_pkg::OFF_MASK2, 32'hffffffff, 1, 32'h00080000, 0},
        '{c2dma_pkg::OFF_MASK2, 0, 1, 0, 0},
        // level 4 unmasked before any start
        '{c2dma_pkg::OFF_MASK4, 32'h00080000, 1, 32'h00080000, 0},
        '{c2dma_pkg::OFF_ESTAT, 32'hffffffff, 1, 0, 0},
        '{12'h010, 32'h5, 1, 0, c2dma_pkg::RESP_SLVERR},
        '{c2dma_pkg::OFF_DEST, 32'h11400000, 1, 32'h11400000, 0}};
    logic [31:0] badLen[3] = '{32'h21, 32'h01000020, 32'h0};
    logic [31:0] winDst[3] = '{32'h10800000, 32'h10000000, 32'h13000000};
    c2dma_pkg::c2dma_route_t winRt[3] = '{c2dma_pkg::RT_YUV, c2dma_pkg::RT_CONV,
        c2dma_pkg::RT_DIRECT};

    always #20 mclk = ~mclk;

    c2dma_ctrl i_c2dma_ctrl (.mclk(mclk), .rst(rst), .axiReq(req), .axiRsp(rsp),
        .srcReq(srcReq), .srcUnitValid(srcUnitValid), .srcUnitReady(srcUnitReady),
        .srcData(srcData), .dstValid(dstValid), .dstAddr(dstAddr), .dstRoute(dstRoute),
        .dstData(dstData), .chanIrqEnDrv(chanIrqEnDrv), .irqLevel2(irqLevel2),
        .irqLevel4(irqLevel4), .irqLevel6(irqLevel6));
    c2dma_src_model i_c2dma_src_model (.mclk(mclk), .rst(rst), .srcReq(srcReq),
        .srcUnitReady(srcUnitReady), .slow(slow), .srcUnitValid(srcUnitValid),
        .srcData(srcData));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // write cycle: both halves offered together, each dropped once taken
    task automatic axW(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (req.awvalid === 1'b1 && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid === 1'b1 && rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                chk(rsp.bresp, er);
                req.bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdv(input logic [11:0] a);
        @(posedge mclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (req.arvalid === 1'b1 && rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                rd = rsp.rdata;
                rr = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axR(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        rdv(a);
        chk(rd, e);
        chk(rr, er);
    endtask

    // polls the start register; a stop is only finished once it reads zero
    task automatic waitIdle();
        repeat (100) begin
            rdv(c2dma_pkg::OFF_START);
            if (rd === 32'h0) break;
        end
        chk(rd, 32'h0);
    endtask

    task automatic go(input logic [31:0] d, input logic [31:0] l, input logic y);
        expAddr = d;
        expYuv = y;
        base = unitCnt;
        axR(c2dma_pkg::OFF_START, 32'h0, 0);
        axW(c2dma_pkg::OFF_DEST, d, 0);
        axW(c2dma_pkg::OFF_LEN, l, 0);
        axW(c2dma_pkg::OFF_START, 32'h1, 0);
    endtask

    // destination monitor: address steps 32 per unit except into the yuv window
    always @(posedge mclk) begin
        if (rst) unitCnt <= '0;
        else if (dstValid === 1'b1) begin
            chk(dstAddr, expAddr);
            chk(dstRoute, expRoute);
            chk(dstData, {8{unitCnt}});
            expAddr = expYuv ? expAddr : expAddr + 32'h20;
            unitCnt <= unitCnt + 32'h1;
        end
    end

    // a hang counts as a mismatch and closes the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            end_sim();
        end
    end

    initial begin
        req = '0;
        rst = 1'b1;
        slow = 1'b0;
        expRoute = c2dma_pkg::RT_DIRECT;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) axW(rows[i].a, rows[i].d, rows[i].r);
            axR(rows[i].a, rows[i].e, rows[i].r);
        end
        // normal end, level 4 unmasked only
        go(32'h11400000, 32'h60, 0);
        waitIdle();
        chk(unitCnt - base, 32'h3);
        axR(c2dma_pkg::OFF_NSTAT, 32'h00080000, 0);
        chk({irqLevel2, irqLevel4, irqLevel6}, 3'b010);
        axR(c2dma_pkg::OFF_DEST, 32'h11400060, 0);
        axR(c2dma_pkg::OFF_LEN, 32'h0, 0);
        axW(c2dma_pkg::OFF_NSTAT, 32'h00080000, 0);
        axR(c2dma_pkg::OFF_NSTAT, 32'h0, 0);
        chk(irqLevel4, 1'b0);
        // stop mid-transfer with a slow source, then resume
        slow <= 1'b1;
        go(32'h11400000, 32'h100, 0);
        axW(c2dma_pkg::OFF_START, 32'h0, 0);
        waitIdle();
        n = unitCnt - base;
        chk(n < 32'h8, 1'b1);
        chk(srcReq, 1'b0);
        axR(c2dma_pkg::OFF_LEN, 32'h100 - 32'h20 * n, 0);
        axR(c2dma_pkg::OFF_DEST, 32'h11400000 + 32'h20 * n, 0);
        axR(c2dma_pkg::OFF_NSTAT, 32'h0, 0);
        chk(irqLevel4, 1'b0);
        axW(c2dma_pkg::OFF_START, 32'h1, 0);
        waitIdle();
        chk(unitCnt - base, 32'h8);
        axW(c2dma_pkg::OFF_NSTAT, 32'h00080000, 0);
        // each destination window, fresh starts after the stop
        // yuv base and control count as set up outside this block first
        slow <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            expRoute = winRt[i];
            go(winDst[i], 32'h40, i == 0);
            waitIdle();
            axR(c2dma_pkg::OFF_DEST, winDst[i] + (i == 0 ? 0 : 32'h40), 0);
            axR(c2dma_pkg::OFF_LEN, 32'h0, 0);
            axW(c2dma_pkg::OFF_NSTAT, 32'h00080000, 0);
        end
        // lengths outside the legal range never start the channel
        foreach (badLen[i]) begin
            axW(c2dma_pkg::OFF_LEN, badLen[i], 0);
            axW(c2dma_pkg::OFF_START, 32'h1, 0);
            axR(c2dma_pkg::OFF_START, 32'h0, 0);
        end
        // interrupt-enable drive from this side
        axW(c2dma_pkg::OFF_AUX, 32'h1, 0);
        chk(chanIrqEnDrv, 1'b1);
        axW(c2dma_pkg::OFF_AUX, 32'h0, 0);
        chk(chanIrqEnDrv, 1'b0);
        // reset in mid-run returns the channel to idle
        slow <= 1'b1;
        go(32'h11400000, 32'h100, 0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        axR(c2dma_pkg::OFF_START, 32'h0, 0);
        axR(c2dma_pkg::OFF_LEN, 32'h0, 0);
        chk(srcReq, 1'b0);
        end_sim();
    end
endmodule
